// ===== rtl/pmic_i2c_regs.svh
// Constants of the framed I2C target port
// Summary of operation
// - I2C target, standard through high-speed rates
// - Two target addresses, main and fail-safe
// - Address bits fixed by one-time configuration
// - Address top bits 0,1 then four configured
// - Address low bit picks the domain
// - Forty-bit frame, fields in fixed order
// - Eight-bit CRC over first 32 bits
// - CRC polynomial 0x1D, preload all ones
`ifndef PMIC_I2C_REGS_SVH
`define PMIC_I2C_REGS_SVH
// Fixed upper two bits of the 7-bit target address
`define TGT_ADDR_HI 2'b01
// CRC generator low byte and preload value
`define CRC_POLY 8'h1D
`define CRC_SEED 8'hFF
// Bits per byte before the acknowledge slot
`define BITS_PER_BYTE 4'h8
// Byte positions after the address byte in a write frame
`define BYTE_INDEX 3'h0
`define BYTE_DMSB 3'h1
`define BYTE_DLSB 3'h2
`define BYTE_CRC 3'h3
// Last byte index returned in a read frame
`define TX_LAST 2'h2
`endif

// ===== rtl/pmic_i2c_pkg.sv
// Types of the framed I2C target port
package pmic_i2c_pkg;
    // Bus engine states, Gray coded in declaration order
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_RX = 3'b011,
        ST_ACKW = 3'b010,
        ST_ACK = 3'b110,
        ST_TX = 3'b111,
        ST_MACK = 3'b101
    } link_state_t;
endpackage

// ===== rtl/pmic_i2c_frame_target.sv
// I2C target that receives and returns 40-bit CRC protected frames
`timescale 1ns/1ps
`include "pmic_i2c_regs.svh"
module pmic_i2c_frame_target
    import pmic_i2c_pkg::*;
(
    // Clock, reset, enable
    input wire logic clock,
    input wire logic rst_b,
    input wire logic clk_en,
    // One-time configured address bits
    input wire logic [3:0] otp_addr_bits,
    // I2C pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Register side
    output logic wr_valid,
    output logic rd_req,
    output logic domain_select_bit,
    output logic [5:0] reg_index,
    output logic [15:0] wr_data,
    input wire logic [15:0] rd_data,
    // Communication error event
    output logic com_err
);
    // Serial CRC, MSB first, over 32 frame bits
    function automatic logic [7:0] crc8_32(input logic [31:0] d);
        logic [7:0] c;
        logic fb;
        c = `CRC_SEED;
        fb = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            fb = c[7] ^ d[i];
            c = {c[6:0], 1'b0} ^ (fb ? `CRC_POLY : 8'h00);
        end
        return c;
    endfunction

    // Synchronisers and filtered pin levels
    logic [2:0] scl_s, sda_s;
    logic scl_f, sda_f, scl_q, sda_q;
    // Configured address bits and capture flag
    logic [3:0] otp_r;
    logic otp_ok_r;
    // Engine state and counters
    link_state_t state_r;
    logic [3:0] bit_cnt_r;
    logic [2:0] byte_cnt_r;
    logic [1:0] tx_cnt_r;
    logic [7:0] shreg_r, tx_sh_r, crc_rx_r;
    logic [31:0] msg_r;
    logic ack_r, rw_r, macked_r;
    logic [15:0] rd_data_r;
    // Output flops
    logic sda_out_r, sda_oe_r, wr_valid_r, rd_req_r, dom_r, com_err_r;
    logic [5:0] reg_index_r;
    logic [15:0] wr_data_r;

    // Bus events from filtered levels
    wire scl_rise = scl_f & ~scl_q;
    wire scl_fall = ~scl_f & scl_q;
    wire start_ev = ~sda_f & sda_q & scl_f & scl_q;
    wire stop_ev = sda_f & ~sda_q & scl_f & scl_q;
    // Byte completed at this rising edge
    wire [7:0] nb = {shreg_r[6:0], sda_f};
    // Address match on fixed and configured bits
    wire addr_hit = (nb[7:6] == `TGT_ADDR_HI) && (nb[5:2] == otp_r) && otp_ok_r;
    // Frame check: CRC and zero padding above the index
    wire crc_ok = (crc8_32(msg_r) == nb) && (msg_r[23:22] == 2'b00);
    // Read data bytes, then CRC over address, index and data
    logic [7:0] tx_byte0, tx_byte_n;

    // Pick the byte to send for a given slot
    function automatic logic [7:0] tx_pick(input logic [1:0] idx, input logic [31:0] f);
        case (idx)
            2'h0: return f[15:8];
            2'h1: return f[7:0];
            default: return crc8_32(f);
        endcase
    endfunction

    always_comb begin
        tx_byte0 = tx_pick(2'h0, {msg_r[31:16], rd_data_r});
        tx_byte_n = tx_pick(2'(tx_cnt_r + 2'h1), {msg_r[31:16], rd_data_r});
    end

    // Three-stage pin synchronisers; change taken when stages 2 and 3 agree
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            scl_s <= 3'b111;
            sda_s <= 3'b111;
            scl_f <= 1'b1;
            sda_f <= 1'b1;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else if (clk_en) begin
            scl_s <= {scl_s[1:0], scl_in};
            sda_s <= {sda_s[1:0], sda_in};
            // Level filter
            if (scl_s[1] == scl_s[2]) begin
                scl_f <= scl_s[2];
            end
            if (sda_s[1] == sda_s[2]) begin
                sda_f <= sda_s[2];
            end
            scl_q <= scl_f;
            sda_q <= sda_f;
        end
    end

    // Address bits caught once after reset release, then frozen
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            otp_r <= 4'h0;
            otp_ok_r <= 1'b0;
        end else if (clk_en && !otp_ok_r) begin
            otp_r <= otp_addr_bits;
            otp_ok_r <= 1'b1;
        end
    end

    // Read data latched one cycle after the request
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rd_data_r <= 16'h0000;
        end else if (clk_en && rd_req_r) begin
            rd_data_r <= rd_data;
        end
    end

    // Bus engine: address, frame bytes, acknowledge, read return
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= ST_IDLE;
            bit_cnt_r <= 4'h0;
            byte_cnt_r <= 3'h0;
            tx_cnt_r <= 2'h0;
            shreg_r <= 8'h00;
            tx_sh_r <= 8'h00;
            crc_rx_r <= 8'h00;
            msg_r <= 32'h0000_0000;
            ack_r <= 1'b0;
            rw_r <= 1'b0;
            macked_r <= 1'b0;
            sda_out_r <= 1'b0;
            sda_oe_r <= 1'b0;
            wr_valid_r <= 1'b0;
            rd_req_r <= 1'b0;
            dom_r <= 1'b0;
            com_err_r <= 1'b0;
            reg_index_r <= 6'h00;
            wr_data_r <= 16'h0000;
        end else if (clk_en) begin
            // Event outputs are single-cycle
            wr_valid_r <= 1'b0;
            rd_req_r <= 1'b0;
            com_err_r <= 1'b0;
            if (start_ev) begin
                // Start or repeated start
                state_r <= ST_ADDR;
                bit_cnt_r <= 4'h0;
                sda_oe_r <= 1'b0;
            end else if (stop_ev) begin
                // Write cut short after the first data byte is malformed
                if (state_r == ST_RX && !rw_r &&
                    (byte_cnt_r == `BYTE_DLSB || byte_cnt_r == `BYTE_CRC)) begin
                    com_err_r <= 1'b1;
                end
                state_r <= ST_IDLE;
                sda_oe_r <= 1'b0;
            end else if (scl_rise) begin
                case (state_r)
                    ST_ADDR: begin
                        shreg_r <= nb;
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                        if (bit_cnt_r == `BITS_PER_BYTE - 4'h1) begin
                            state_r <= ST_ACKW;
                            ack_r <= addr_hit;
                            if (addr_hit) begin
                                rw_r <= nb[0];
                                dom_r <= nb[1];
                                msg_r[31:24] <= nb;
                                byte_cnt_r <= `BYTE_INDEX;
                                rd_req_r <= nb[0];
                                msg_r[23:16] <= {2'b00, reg_index_r};
                            end
                        end
                    end
                    ST_RX: begin
                        shreg_r <= nb;
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                        if (bit_cnt_r == `BITS_PER_BYTE - 4'h1) begin
                            state_r <= ST_ACKW;
                            ack_r <= 1'b1;
                            byte_cnt_r <= byte_cnt_r + 3'h1;
                            case (byte_cnt_r)
                                // Index byte, also the pointer for reads
                                `BYTE_INDEX: begin
                                    msg_r[23:16] <= nb;
                                    reg_index_r <= nb[5:0];
                                end
                                `BYTE_DMSB: msg_r[15:8] <= nb;
                                `BYTE_DLSB: msg_r[7:0] <= nb;
                                `BYTE_CRC: begin
                                    crc_rx_r <= nb;
                                    if (crc_ok) begin
                                        wr_valid_r <= 1'b1;
                                        wr_data_r <= msg_r[15:0];
                                    end else begin
                                        // Write dropped and refused
                                        ack_r <= 1'b0;
                                        com_err_r <= 1'b1;
                                    end
                                end
                                default: begin
                                    // Bytes beyond the frame
                                    ack_r <= 1'b0;
                                    com_err_r <= 1'b1;
                                end
                            endcase
                        end
                    end
                    ST_TX: bit_cnt_r <= bit_cnt_r + 4'h1;
                    // Controller acknowledge sampled
                    ST_MACK: macked_r <= ~sda_f;
                    default: ;
                endcase
            end else if (scl_fall) begin
                case (state_r)
                    // Drive the acknowledge slot
                    ST_ACKW: begin
                        sda_oe_r <= ack_r;
                        state_r <= ST_ACK;
                    end
                    ST_ACK: begin
                        bit_cnt_r <= 4'h0;
                        if (!ack_r) begin
                            sda_oe_r <= 1'b0;
                            state_r <= ST_IDLE;
                        end else if (rw_r) begin
                            // First read byte, MSB first
                            tx_cnt_r <= 2'h0;
                            tx_sh_r <= tx_byte0;
                            sda_oe_r <= ~tx_byte0[7];
                            state_r <= ST_TX;
                        end else begin
                            sda_oe_r <= 1'b0;
                            state_r <= ST_RX;
                        end
                    end
                    ST_TX: begin
                        if (bit_cnt_r == `BITS_PER_BYTE) begin
                            sda_oe_r <= 1'b0;
                            state_r <= ST_MACK;
                        end else begin
                            tx_sh_r <= {tx_sh_r[6:0], 1'b0};
                            sda_oe_r <= ~tx_sh_r[6];
                        end
                    end
                    ST_MACK: begin
                        if (macked_r && tx_cnt_r != `TX_LAST) begin
                            tx_cnt_r <= tx_cnt_r + 2'h1;
                            tx_sh_r <= tx_byte_n;
                            sda_oe_r <= ~tx_byte_n[7];
                            bit_cnt_r <= 4'h0;
                            state_r <= ST_TX;
                        end else begin
                            state_r <= ST_IDLE;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // Outputs straight from flops
    assign sda_out = sda_out_r;
    assign sda_oe = sda_oe_r;
    assign wr_valid = wr_valid_r;
    assign rd_req = rd_req_r;
    assign domain_select_bit = dom_r;
    assign reg_index = reg_index_r;
    assign wr_data = wr_data_r;
    assign com_err = com_err_r;

    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    sequence s_wr_pulse;
        wr_valid_r ##1 !wr_valid_r;
    endsequence

    AST_WR_CRC: assert property (wr_valid_r |-> crc8_32(msg_r) == crc_rx_r)
        else $error("write accepted with bad CRC");
    AST_WR_ADDR: assert property (wr_valid_r |-> msg_r[31:30] == 2'b01 && msg_r[29:26] == otp_r)
        else $error("write accepted on foreign address");
    AST_WR_DOMAIN: assert property (wr_valid_r |-> dom_r == msg_r[25] && !msg_r[24])
        else $error("domain bit mismatch");
    AST_WR_FIELDS: assert property (wr_valid_r |-> msg_r[23:22] == 2'b00 &&
        reg_index_r == msg_r[21:16] && wr_data_r == msg_r[15:0])
        else $error("frame fields misplaced");
    AST_ERR_NOWR: assert property (com_err_r |-> !wr_valid_r)
        else $error("write and error together");
    AST_OTP_FROZEN: assert property (otp_ok_r && clk_en |=> $stable(otp_r))
        else $error("address bits changed");
    AST_WR_ONCE: assert property (wr_valid_r && clk_en |-> s_wr_pulse)
        else $error("write pulse longer than one cycle");
    AST_NACK_CRC: assert property (com_err_r && state_r == ST_ACKW |-> !ack_r)
        else $error("bad frame acknowledged");
    AST_RD_ADDR: assert property (rd_req_r |-> msg_r[24] && msg_r[31:30] == 2'b01 &&
        dom_r == msg_r[25])
        else $error("read request without matching address");
endmodule

// ===== verif/i2c_ctl_model.sv
// Behavioural I2C bus controller that frames transfers toward the target
`timescale 1ns/1ps
module i2c_ctl_model (
    // Clock and resolved data wire
    input wire logic clock,
    input wire logic sda_line,
    // Open-drain controls onto the bus
    output logic scl,
    output logic sda_low
);
    // Bus released, clock parked high
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // Wait system clock edges
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    // Start, or repeated start from the low phase
    task automatic start();
        sda_low <= 1'b0;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sda_low <= 1'b1;
        tick(4);
        scl <= 1'b0;
        tick(2);
    endtask
    // Stop, then the clock stands still high
    task automatic stop();
        sda_low <= 1'b1;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sda_low <= 1'b0;
        tick(8);
    endtask
    // One driven bit, 800 ns period
    task automatic bit_out(input logic b);
        sda_low <= ~b;
        tick(2);
        scl <= 1'b1;
        tick(4);
        scl <= 1'b0;
        tick(2);
    endtask
    // One bit driven by the target; both low phases stretched because the
    // target drives five clocks after it sees the fall, so SCL must not rise
    // before its data has settled on the wire and through its filter
    task automatic bit_in(output logic b);
        sda_low <= 1'b0;
        tick(5);
        scl <= 1'b1;
        tick(3);
        b = sda_line;
        tick(1);
        scl <= 1'b0;
        tick(4);
    endtask
    // Byte out, MSB first, then acknowledge slot
    task automatic send_byte(input logic [7:0] v, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) bit_out(v[i]);
        bit_in(b);
        ack = ~b;
    endtask
    // Byte in, MSB first, then our acknowledge or not
    task automatic recv_byte(input logic ack, output logic [7:0] v);
        for (int i = 7; i >= 0; i--) bit_in(v[i]);
        bit_out(~ack);
    endtask
endmodule

// ===== verif/pmic_i2c_frame_target_test.sv
// Self-checking bench of the framed I2C target
`timescale 1ns/1ps
module pmic_i2c_frame_target_test;
    import pmic_i2c_pkg::*;
    // Frame case: config, address byte, index, data, CRC flip, bytes, outcomes
    typedef struct {
        logic [3:0] otp; logic [7:0] a; logic [7:0] ix; logic [15:0] d;
        logic [7:0] cx; int nb; logic ack; logic wr; logic er;
    } row_t;
    logic clock = 1'b0, rst_b = 1'b0, clk_en = 1'b1;
    logic [3:0] otp_addr_bits = 4'h0;
    logic [15:0] rd_data = 16'h0000;
    logic scl, ctl_low, sda_oe, sda_out, wr_valid, rd_req, domain_select_bit, com_err;
    logic [5:0] reg_index;
    logic [15:0] wr_data, cap_d;
    logic [5:0] cap_ix;
    logic cap_dom, ack;
    logic [7:0] b [5];
    logic [7:0] v [3];
    wire logic sda_line;
    int error_cnt = 0, compares = 0, wr_cnt = 0, err_cnt = 0, rd_cnt = 0, cyc = 0;
    row_t rows [11], r;
    // Open-drain wire with pull-up
    assign sda_line = ~((sda_oe & ~sda_out) | ctl_low);
    pmic_i2c_frame_target pmic_i2c_frame_target_i (.clock(clock), .rst_b(rst_b),
        .clk_en(clk_en), .otp_addr_bits(otp_addr_bits), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .wr_valid(wr_valid), .rd_req(rd_req),
        .domain_select_bit(domain_select_bit), .reg_index(reg_index), .wr_data(wr_data),
        .rd_data(rd_data), .com_err(com_err));
    i2c_ctl_model i2c_ctl_model_i (.clock(clock), .sda_line(sda_line), .scl(scl),
        .sda_low(ctl_low));
    // 10 MHz clock
    initial forever #50 clock = ~clock;
    // Pulse counters and write capture; hang guard
    always @(posedge clock) begin
        cyc++;
        if (wr_valid === 1'b1) begin
            wr_cnt++;
            cap_d = wr_data;
            cap_ix = reg_index;
            cap_dom = domain_select_bit;
        end
        if (com_err === 1'b1) err_cnt++;
        if (rd_req === 1'b1) rd_cnt++;
        if (cyc == 20000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    // Reference CRC, MSB first, seed all ones
    function automatic logic [7:0] crc8(input logic [31:0] m);
        logic [7:0] c;
        c = 8'hFF;
        for (int i = 31; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ m[i]) ? 8'h1D : 8'h00);
        return c;
    endfunction
    task automatic chk_bit(input logic got, input logic exp, input string what);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t %s", $time, what);
        end
    endtask
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask
    // Reset pulse, four cycles
    task automatic do_reset();
        rst_b <= 1'b0;
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        repeat (4) @(posedge clock);
    endtask
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        rows = '{'{4'h0, 8'h40, 8'h02, 16'h0000, 8'h00, 4, 1, 1, 0},
            '{4'h0, 8'h42, 8'h01, 16'hD00D, 8'h00, 4, 1, 1, 0},
            '{4'h5, 8'h54, 8'h3F, 16'hFFFF, 8'h00, 4, 1, 1, 0},
            '{4'h5, 8'h40, 8'h02, 16'h0000, 8'h00, 4, 0, 0, 0},
            '{4'h0, 8'hC0, 8'h02, 16'h0000, 8'h00, 4, 0, 0, 0},
            '{4'h0, 8'h00, 8'h02, 16'h0000, 8'h00, 4, 0, 0, 0},
            '{4'h0, 8'h40, 8'h05, 16'h1234, 8'h01, 4, 1, 0, 1},
            '{4'h0, 8'h40, 8'h45, 16'h1234, 8'h00, 4, 1, 0, 1},
            '{4'h0, 8'h40, 8'h05, 16'h1234, 8'h00, 2, 1, 0, 1},
            '{4'h0, 8'h40, 8'h05, 16'h1234, 8'h00, 5, 1, 1, 1},
            '{4'h0, 8'h40, 8'h06, 16'hABCD, 8'h00, 1, 1, 0, 0}};
        // Outputs quiet while held in reset
        repeat (4) @(posedge clock);
        chk_bit(sda_oe | wr_valid | com_err | rd_req, 1'b0, "reset quiet");
        chk_word({8'h00, crc8(32'h4002_0000)}, 16'h0031, "crc ref a");
        chk_word({8'h00, crc8(32'h4201_D00D)}, 16'h008C, "crc ref b");
        // Write frame table
        for (int k = 0; k < 11; k++) begin
            r = rows[k];
            otp_addr_bits <= r.otp;
            do_reset();
            b = '{r.ix, r.d[15:8], r.d[7:0], crc8({r.a, r.ix, r.d}) ^ r.cx, 8'h00};
            wr_cnt = 0;
            err_cnt = 0;
            i2c_ctl_model_i.start();
            i2c_ctl_model_i.send_byte(r.a, ack);
            chk_bit(ack, r.ack, "address ack");
            if (ack === 1'b1) for (int j = 0; j < r.nb; j++) i2c_ctl_model_i.send_byte(b[j], ack);
            i2c_ctl_model_i.stop();
            chk_word(16'(wr_cnt), {15'h0000, r.wr}, "write count");
            chk_word(16'(err_cnt), {15'h0000, r.er}, "error count");
            if (r.wr) begin
                chk_word(cap_d, r.d, "write data");
                chk_word({10'h000, cap_ix}, {10'h000, r.ix[5:0]}, "write index");
                chk_bit(cap_dom, r.a[1], "domain");
            end
            $display("row %0d done", k);
        end
        // Read: index write, repeated start, three bytes back
        otp_addr_bits <= 4'h0;
        rd_data <= 16'hC3A5;
        do_reset();
        rd_cnt = 0;
        i2c_ctl_model_i.start();
        i2c_ctl_model_i.send_byte(8'h40, ack);
        i2c_ctl_model_i.send_byte(8'h07, ack);
        i2c_ctl_model_i.start();
        i2c_ctl_model_i.send_byte(8'h41, ack);
        chk_bit(ack, 1'b1, "read address ack");
        i2c_ctl_model_i.recv_byte(1'b1, v[0]);
        i2c_ctl_model_i.recv_byte(1'b1, v[1]);
        i2c_ctl_model_i.recv_byte(1'b0, v[2]);
        i2c_ctl_model_i.stop();
        chk_word(16'(rd_cnt), 16'h0001, "read requests");
        chk_word({v[0], v[1]}, 16'hC3A5, "read data");
        chk_word({8'h00, v[2]}, {8'h00, crc8(32'h4107_C3A5)}, "read crc");
        chk_bit(domain_select_bit, 1'b0, "read domain");
        $display("read done");
        // Clock enable low: target frozen, address not acknowledged
        clk_en <= 1'b0;
        i2c_ctl_model_i.start();
        i2c_ctl_model_i.send_byte(8'h40, ack);
        i2c_ctl_model_i.stop();
        clk_en <= 1'b1;
        chk_bit(ack, 1'b0, "frozen no ack");
        $display("freeze done");
        report_and_stop();
    end
endmodule
